// >>> dv/test_adc_repeat_buffer_calibration_regs.sv
// Self-checking bench for the ADC repeat, buffer and calibration register block
`timescale 1ns/10ps
`include "adc_cal_regs_map.svh"

module test_adc_repeat_buffer_calibration_regs;
   localparam logic [1:0] okay = `AXI_RESP_OKAY;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] awaddr = '0, araddr = '0, cdata = '0, res;
   logic [31:0] wdata = '0, rdata, lk, d;
   logic [3:0] wstrb = 4'hF, st = 4'hF;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cstart = 0, cvalid = 0;
   logic awready, wready, bvalid, arready, rvalid, creq, rvld, busy, done, ren;
   logic [1:0] bresp, rresp;
   logic [7:0] rcnt;
   logic [4:0] amp;
   logic [3:0] chop;
   adc_cal_regs_pkg::meas_channel_t chan = adc_cal_regs_pkg::LOW_POWER_TIA;
   adc_cal_regs_pkg::pga_gain_t pga = adc_cal_regs_pkg::PGA_GAIN_1;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [15:0] cq[$];
   int err_total = 0, compares = 0, seed = 71093, ndone = 0, nreq = 0;
   logic [31:0] v[16];
   // Gains first, offsets second, both ordered temp, low power, high speed, aux 1/1.5/2/4/9
   logic [15:0] cal_a[16] = '{`GAIN_TEMP_ADDR, `GAIN_LP_TIA_ADDR, `GAIN_HS_TIA_ADDR,
      `GAIN_AUX_G1_ADDR, `GAIN_AUX_G1P5_ADDR, `GAIN_AUX_G2_ADDR, `GAIN_AUX_G4_ADDR,
      `GAIN_AUX_G9_ADDR, `OFS_TEMP_ADDR, `OFS_LP_TIA_ADDR, `OFS_HS_TIA_ADDR, `OFS_AUX_G1_ADDR,
      `OFS_AUX_G1P5_ADDR, `OFS_AUX_G2_ADDR, `OFS_AUX_G4_ADDR, `OFS_AUX_G9_ADDR};

   adc_repeat_buffer_calibration_regs u_dut (.core_clk_in(clk), .reset_in(rst),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .conv_start_in(cstart),
      .conv_request_out(creq), .conv_valid_in(cvalid), .conv_data_in(cdata),
      .conv_channel_in(chan), .conv_pga_gain_in(pga), .result_data_out(res),
      .result_valid_out(rvld), .repeat_busy_out(busy), .repeat_done_out(done),
      .repeat_enable_out(ren), .repeat_count_out(rcnt), .amplifier_disable_field_out(amp),
      .chop_disable_field_out(chop));

   always #10 clk = ~clk;

   task automatic tally(input logic bad, input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (bad) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
      tally(got !== exp, got, exp);
   endtask
   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      tally(got !== exp, 34'(got), 34'(exp));
   endtask
   task automatic cmp_res(input logic [15:0] got, input logic [15:0] exp);
      tally(got !== exp, 34'(got), 34'(exp));
   endtask

   // Handshakes are sampled at the falling edge, where every level is settled
   always @(negedge clk) begin
      if (bvalid && bready) cmp_resp(bresp, bq.pop_front());
      if (rvalid && rready) cmp_word({rresp, rdata}, rq.pop_front());
      if (rvld) cmp_res(res, cq.pop_front());
      if (creq) nreq++;
      if (done) ndone++;
   end

   task automatic wr(input logic [15:0] a, input logic [31:0] dw, input logic [1:0] r);
      logic ta, tw, tb;
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= dw;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bq.push_back(r);
      do begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end while (!tb && n < 40);
      if (!tb) err_total++;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] dr, input logic [1:0] r);
      logic ta, tr;
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rq.push_back({r, dr});
      do begin
         @(negedge clk);
         ta = arvalid && arready;
         tr = rvalid;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         n++;
      end while (!tr && n < 40);
      if (!tr) err_total++;
      rready <= 1'b0;
   endtask

   // Raw code times four plus the quarter-LSB offset, scaled by gain over 0x10000, clamped
   function automatic logic [15:0] corr(logic [15:0] x, logic [14:0] g, logic [14:0] o);
      longint c;
      c = ((longint'(x) * 4 + longint'($signed(o))) * longint'(g)) >>> 16;
      return (c < 0) ? 16'h0000 : (c > 65535) ? 16'hFFFF : c[15:0];
   endfunction

   // Combo j picks the channel and aux gain whose calibration pair sits at v[j], v[j+8]
   task automatic conv(input int n, input int j);
      logic [15:0] x;
      int k, w, d0, r0;
      d0 = ndone;
      r0 = nreq;
      @(posedge clk);
      chan <= adc_cal_regs_pkg::meas_channel_t'((j == 0) ? 3 : (j < 3) ? j - 1 : 2);
      pga <= adc_cal_regs_pkg::pga_gain_t'((j > 3) ? j - 3 : 0);
      cstart <= 1'b1;
      @(posedge clk);
      cstart <= 1'b0;
      for (k = 0; k < n; k++) begin
         w = 0;
         do begin
            @(negedge clk);
            w++;
         end while (!creq && w < 20);
         if (!creq) err_total++;
         x = 16'($random(seed));
         @(posedge clk);
         cdata <= x;
         cvalid <= 1'b1;
         cq.push_back(corr(x, v[j][14:0], v[j + 8][14:0]));
         @(posedge clk);
         cvalid <= 1'b0;
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
      cmp_word(34'(nreq - r0), 34'(n));
      cmp_word(34'(ndone - d0), 34'd1);
      cmp_word(34'(busy), 34'd0);
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #400000;
      err_total++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      cmp_word({ren, rcnt, amp, chop}, {1'b0, 8'h16, 5'h10, 4'h0});
      rd(`RPT_CTRL_ADDR, `RPT_CTRL_RESET, okay);
      rd(`BUF_CFG_ADDR, 32'h005F_3D00, okay);
      rd(16'h2100, 32'h0, `AXI_RESP_SLVERR);
      wr(16'h2104, 32'h1, `AXI_RESP_SLVERR);
      // Aux gain 1 pair is unity gain with a one-LSB offset
      for (int i = 0; i < 16; i++) begin
         v[i] = (i == 7) ? 32'h0 : (i == 3) ? 32'h4000 : (i == 11) ? 32'h4 : $random(seed);
      end
      // Phases: still locked, unlocked by the key, relocked by a near miss
      for (int p = 0; p < 3; p++) begin
         lk = (p == 0) ? 32'h0 : (p == 1) ? `CAL_UNLOCK_KEY : `CAL_UNLOCK_KEY ^ 32'h1;
         wr(`CAL_LOCK_ADDR, lk, okay);
         rd(`CAL_LOCK_ADDR, lk, okay);
         for (int i = 0; i < 16; i++) begin
            wr(cal_a[i], (p == 1) ? v[i] : ~v[i], okay);
            d = (p > 0) ? v[i] & 32'h7FFF : (i < 8) ? 32'h4000 : 32'h0;
            rd(cal_a[i], d, okay);
         end
      end
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 32'h005F_3D0F : (k == 1) ? 32'h005F_3D04 : $random(seed);
         wr(`BUF_CFG_ADDR, d, okay);
         rd(`BUF_CFG_ADDR, {23'h002F9E, d[8:0]}, okay);
         cmp_word(34'({amp, chop}), 34'(d[8:0]));
      end
      // Byte strobe: only bit 8 of the fields lies in byte 1
      st = 4'h2;
      wr(`BUF_CFG_ADDR, 32'h0, okay);
      st = 4'hF;
      rd(`BUF_CFG_ADDR, {23'h002F9E, 1'b0, d[7:0]}, okay);
      cmp_word(34'({amp, chop}), 34'({1'b0, d[7:0]}));
      for (int r = 0; r < 4; r++) begin
         d = (r == 0) ? 32'hFFFF_F031 : (r == 1) ? 32'hFF1 : (r == 2) ? 32'h050 : 32'h011;
         wr(`RPT_CTRL_ADDR, d, okay);
         rd(`RPT_CTRL_ADDR, d & 32'hFF1, okay);
         cmp_word(34'({ren, rcnt}), 34'({d[0], d[11:4]}));
         conv((r == 0) ? 3 : (r == 1) ? 256 : 1, r);
      end
      for (int j = 4; j < 8; j++) conv(1, j);
      report_and_stop();
   end
endmodule

// >>> hdl/adc_repeat_buffer_calibration_regs.sv
// ADC repeat controller, buffer configuration and locked calibration registers on AXI4-Lite
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "adc_cal_regs_map.svh"

module adc_repeat_buffer_calibration_regs #(
   parameter int ADDR_WIDTH = 16,
   parameter int RESULT_WIDTH = 16
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic conv_start_in,
   output logic conv_request_out,
   input wire logic conv_valid_in,
   input wire logic [RESULT_WIDTH-1:0] conv_data_in,
   input wire adc_cal_regs_pkg::meas_channel_t conv_channel_in,
   input wire adc_cal_regs_pkg::pga_gain_t conv_pga_gain_in,
   output logic [RESULT_WIDTH-1:0] result_data_out,
   output logic result_valid_out,
   output logic repeat_busy_out,
   output logic repeat_done_out,
   output logic repeat_enable_out,
   output logic [7:0] repeat_count_out,
   output logic [4:0] amplifier_disable_field_out,
   output logic [3:0] chop_disable_field_out
);

   initial begin
      if (ADDR_WIDTH < 14 || ADDR_WIDTH > 32 || RESULT_WIDTH < 8 || RESULT_WIDTH > 24) begin
         $error("Unsupported address or result width");
      end
   end

   localparam int CAL_ENTRIES = 8;
   // Literals cannot be bit-selected directly, so the reset words are named first
   localparam logic [31:0] RPT_RESET_WORD = `RPT_CTRL_RESET;
   localparam logic [31:0] BUF_RESET_WORD = `BUF_CFG_RESET;

   // Address decode of the calibration words: {hit, is_gain, index}
   function automatic logic [4:0] cal_decode(input logic [15:0] a);
      begin
         case (a)
            `OFS_LP_TIA_ADDR: cal_decode = 5'h10;
            `GAIN_LP_TIA_ADDR: cal_decode = 5'h18;
            `OFS_HS_TIA_ADDR: cal_decode = 5'h11;
            `GAIN_HS_TIA_ADDR: cal_decode = 5'h19;
            `OFS_TEMP_ADDR: cal_decode = 5'h12;
            `GAIN_TEMP_ADDR: cal_decode = 5'h1A;
            `OFS_AUX_G1_ADDR: cal_decode = 5'h13;
            `GAIN_AUX_G1_ADDR: cal_decode = 5'h1B;
            `OFS_AUX_G1P5_ADDR: cal_decode = 5'h14;
            `GAIN_AUX_G1P5_ADDR: cal_decode = 5'h1C;
            `OFS_AUX_G2_ADDR: cal_decode = 5'h15;
            `GAIN_AUX_G2_ADDR: cal_decode = 5'h1D;
            `OFS_AUX_G4_ADDR: cal_decode = 5'h16;
            `GAIN_AUX_G4_ADDR: cal_decode = 5'h1E;
            `OFS_AUX_G9_ADDR: cal_decode = 5'h17;
            `GAIN_AUX_G9_ADDR: cal_decode = 5'h1F;
            default: cal_decode = 5'h00;
         endcase
      end
   endfunction

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
      begin
         for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
         end
         merge_bytes = old;
      end
   endfunction

   // Register state
   logic repeat_enable;
   logic [7:0] repeat_count;
   logic [4:0] amp_disable;
   logic [3:0] chop_disable;
   logic [31:0] lock_value;
   logic [14:0] gain_cal [CAL_ENTRIES];
   logic [14:0] offset_cal [CAL_ENTRIES];
   logic unlocked;

   // AXI write channel holding registers
   logic aw_held;
   logic w_held;
   logic [15:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_fire;
   logic [4:0] wr_cal;
   logic wr_mapped;
   logic [31:0] rpt_word;
   logic [31:0] buf_word;
   logic [31:0] next_rpt;
   logic [31:0] next_buf;
   logic [31:0] next_lock;
   logic [31:0] next_cal;

   // AXI read channel
   logic [15:0] rd_addr;
   logic [4:0] rd_cal;
   logic [31:0] rd_value;
   logic rd_mapped;
   logic [31:0] status_word;

   // Repeat sequencer
   adc_cal_regs_pkg::repeat_state_t repeat_state;
   logic [8:0] run_target;
   logic [8:0] run_done_count;

   // Correction path
   logic [2:0] sel_index;
   logic signed [20:0] offset_sum;
   logic signed [37:0] scaled;
   logic signed [37:0] shifted;

   assign unlocked = (lock_value == `CAL_UNLOCK_KEY);
   assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
   assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
   assign wr_cal = cal_decode(wr_addr);
   assign rpt_word = {20'h0_0000, repeat_count, 3'h0, repeat_enable};
   // upper bits fixed at the reset pattern
   assign buf_word = {23'(BUF_RESET_WORD >> `BUF_FIXED_LSB), amp_disable, chop_disable};
   assign next_rpt = merge_bytes(rpt_word, wr_data, wr_strb);
   assign next_buf = merge_bytes(buf_word, wr_data, wr_strb);
   assign next_lock = merge_bytes(lock_value, wr_data, wr_strb);
   assign next_cal = merge_bytes(32'h0000_0000, wr_data, wr_strb);
   assign wr_mapped = wr_cal[4] || wr_addr == `RPT_CTRL_ADDR || wr_addr == `BUF_CFG_ADDR
      || wr_addr == `CAL_LOCK_ADDR || wr_addr == `STATUS_ADDR;

   assign repeat_enable_out = repeat_enable;
   assign repeat_count_out = repeat_count;
   assign amplifier_disable_field_out = amp_disable;
   assign chop_disable_field_out = chop_disable;

   // Address and data may arrive in either order; each is parked until the other shows up
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         aw_held <= 1'b0;
         wr_addr <= 16'h0000;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_held <= 1'b1;
         wr_addr <= 16'({s_axi_awaddr_in[ADDR_WIDTH-1:2], 2'b00});
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         w_held <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_held <= 1'b1;
         wr_data <= s_axi_wdata_in;
         wr_strb <= s_axi_wstrb_in;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `AXI_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         repeat_enable <= RPT_RESET_WORD[`RPT_EN_BIT];
         repeat_count <= RPT_RESET_WORD[`RPT_COUNT_MSB:`RPT_COUNT_LSB];
      end else if (wr_fire && wr_addr == `RPT_CTRL_ADDR) begin
         repeat_enable <= next_rpt[`RPT_EN_BIT];
         repeat_count <= next_rpt[`RPT_COUNT_MSB:`RPT_COUNT_LSB];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         amp_disable <= BUF_RESET_WORD[`AMP_DIS_MSB:`AMP_DIS_LSB];
         chop_disable <= BUF_RESET_WORD[`CHOP_DIS_MSB:`CHOP_DIS_LSB];
      end else if (wr_fire && wr_addr == `BUF_CFG_ADDR) begin
         amp_disable <= next_buf[`AMP_DIS_MSB:`AMP_DIS_LSB];
         chop_disable <= next_buf[`CHOP_DIS_MSB:`CHOP_DIS_LSB];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         lock_value <= 32'h0000_0000;
      end else if (wr_fire && wr_addr == `CAL_LOCK_ADDR) begin
         lock_value <= next_lock;
      end
   end

   // one offset and gain word per entry
   generate
      for (genvar i = 0; i < CAL_ENTRIES; i++) begin : g_cal
         always_ff @(posedge core_clk_in) begin
            if (reset_in) begin
               gain_cal[i] <= `GAIN_CAL_RESET;
               offset_cal[i] <= `OFFSET_CAL_RESET;
            end else if (wr_fire && unlocked && wr_cal[4] && wr_cal[2:0] == 3'(i)) begin
               if (wr_cal[3]) begin
                  gain_cal[i] <= next_cal[`CAL_FIELD_MSB:0];
               end else begin
                  offset_cal[i] <= next_cal[`CAL_FIELD_MSB:0];
               end
            end
         end
      end
   endgenerate

   // Read side: one outstanding read, data registered
   assign rd_addr = 16'({s_axi_araddr_in[ADDR_WIDTH-1:2], 2'b00});
   assign rd_cal = cal_decode(rd_addr);
   assign status_word = {15'h0000, run_done_count, 6'h00, unlocked, repeat_busy_out};

   always_comb begin
      rd_value = 32'h0000_0000;
      rd_mapped = 1'b1;
      if (rd_cal[4]) begin
         rd_value = {17'h0_0000, rd_cal[3] ? gain_cal[rd_cal[2:0]] : offset_cal[rd_cal[2:0]]};
      end else begin
         case (rd_addr)
            `RPT_CTRL_ADDR: rd_value = rpt_word;
            `BUF_CFG_ADDR: rd_value = buf_word;
            `CAL_LOCK_ADDR: rd_value = lock_value;
            `STATUS_ADDR: rd_value = status_word;
            default: rd_mapped = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `AXI_RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_value;
         s_axi_rresp_out <= rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // Repeat sequencer; a zero count is left to software to avoid and runs a single conversion
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         repeat_state <= adc_cal_regs_pkg::REPEAT_IDLE;
         run_target <= 9'h001;
         run_done_count <= 9'h000;
         conv_request_out <= 1'b0;
         repeat_done_out <= 1'b0;
      end else begin
         conv_request_out <= 1'b0;
         repeat_done_out <= 1'b0;
         case (repeat_state)
            adc_cal_regs_pkg::REPEAT_IDLE: begin
               if (conv_start_in) begin
                  if (!repeat_enable || repeat_count == 8'h00) begin
                     run_target <= 9'h001;
                  end else if (repeat_count == `RPT_COUNT_ALL_ONES) begin
                     run_target <= `RPT_MAX_CONVERSIONS;
                  end else begin
                     run_target <= {1'b0, repeat_count};
                  end
                  run_done_count <= 9'h000;
                  repeat_state <= adc_cal_regs_pkg::REPEAT_REQUEST;
               end
            end
            adc_cal_regs_pkg::REPEAT_REQUEST: begin
               conv_request_out <= 1'b1;
               repeat_state <= adc_cal_regs_pkg::REPEAT_WAIT;
            end
            adc_cal_regs_pkg::REPEAT_WAIT: begin
               if (conv_valid_in) begin
                  run_done_count <= run_done_count + 9'h001;
                  if (run_done_count + 9'h001 >= run_target) begin
                     repeat_done_out <= 1'b1;
                     repeat_state <= adc_cal_regs_pkg::REPEAT_IDLE;
                  end else begin
                     repeat_state <= adc_cal_regs_pkg::REPEAT_REQUEST;
                  end
               end
            end
            default: repeat_state <= adc_cal_regs_pkg::REPEAT_IDLE;
         endcase
      end
   end

   assign repeat_busy_out = (repeat_state != adc_cal_regs_pkg::REPEAT_IDLE);

   // pick the pair of the current channel and PGA gain
   always_comb begin
      case (conv_channel_in)
         adc_cal_regs_pkg::LOW_POWER_TIA: sel_index = 3'h0;
         adc_cal_regs_pkg::HIGH_SPEED_TIA: sel_index = 3'h1;
         adc_cal_regs_pkg::TEMPERATURE_SENSOR: sel_index = 3'h2;
         default: sel_index = 3'h3 + 3'(conv_pga_gain_in);
      endcase
   end

   // offset in quarter LSBs, added before scaling
   assign offset_sum = $signed({3'b000, conv_data_in, 2'b00})
      + 21'(signed'(offset_cal[sel_index]));
   // gain 0x4000 is unity; the extra shift of two drops the quarter-LSB fraction
   assign scaled = 38'(offset_sum * $signed({1'b0, gain_cal[sel_index]}));
   assign shifted = scaled >>> 16;

   // Result clamps to the code range rather than wrapping
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         result_valid_out <= 1'b0;
         result_data_out <= '0;
      end else begin
         result_valid_out <= conv_valid_in;
         if (conv_valid_in) begin
            if (shifted < 0) begin
               result_data_out <= '0;
            end else if (shifted > $signed({22'h0, {RESULT_WIDTH{1'b1}}})) begin
               result_data_out <= '1;
            end else begin
               result_data_out <= shifted[RESULT_WIDTH-1:0];
            end
         end
      end
   end

   // Helper state for checks only
   logic [14:0] cal_signature;
   logic [8:0] req_seen;
   always_comb begin
      cal_signature = 15'h0000;
      for (int k = 0; k < CAL_ENTRIES; k++) begin
         cal_signature = cal_signature ^ gain_cal[k] ^ {offset_cal[k][13:0], offset_cal[k][14]};
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (reset_in || (conv_start_in && !repeat_busy_out)) begin
         req_seen <= 9'h000;
      end else if (conv_request_out) begin
         req_seen <= req_seen + 9'h001;
      end
   end

   chk_repeat_reset: assert property (@(posedge core_clk_in)
      $fell(reset_in) |-> repeat_count == 8'h16 && !repeat_enable)
      else $error("Repeat control reset value wrong");
   chk_buffer_reset: assert property (@(posedge core_clk_in)
      $fell(reset_in) |-> buf_word == 32'h005F_3D00 && amplifier_disable_field_out == 5'h10)
      else $error("Buffer configuration reset value wrong");
   chk_repeat_total: assert property (@(posedge core_clk_in) disable iff (reset_in)
      repeat_done_out |-> req_seen == run_target)
      else $error("Number of conversions differs from target");
   chk_single_conversion: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (conv_start_in && !repeat_busy_out && !repeat_enable) |=> run_target == 9'h001)
      else $error("Disabled repeat ran more than one conversion");
   chk_amp_write: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_fire && wr_addr == `BUF_CFG_ADDR && wr_strb == 4'hF)
      |=> amplifier_disable_field_out == $past(wr_data[8:4])
         && chop_disable_field_out == $past(wr_data[3:0]))
      else $error("Buffer configuration write not applied");
   chk_key_unlocks: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_fire && wr_addr == `CAL_LOCK_ADDR && wr_strb == 4'hF && wr_data == 32'hDE87_A5AF)
      |=> unlocked)
      else $error("Key write did not unlock");
   chk_other_relocks: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_fire && wr_addr == `CAL_LOCK_ADDR && wr_strb == 4'hF && wr_data != 32'hDE87_A5AF)
      |=> !unlocked)
      else $error("Non-key write left calibration unlocked");
   chk_locked_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (wr_fire && wr_cal[4] && !unlocked) |=> $stable(cal_signature))
      else $error("Calibration changed while locked");
   chk_gain_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (conv_valid_in && gain_cal[sel_index] == 15'h0000)
      |=> result_valid_out && result_data_out == '0)
      else $error("Zero gain did not zero the result");
   chk_unity_pass: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (conv_valid_in && gain_cal[sel_index] == 15'h4000 && offset_cal[sel_index] == 15'h0004
         && conv_data_in != '1) |=> result_data_out == $past(conv_data_in) + 1'b1)
      else $error("Offset of one LSB at unity gain not applied");

endmodule

// >>> pkg/adc_cal_regs_map.svh
// Register offsets, field positions, reset values and keys of the ADC control registers
`ifndef ADC_CAL_REGS_MAP_SVH
`define ADC_CAL_REGS_MAP_SVH
`define RPT_CTRL_ADDR 16'h21F0
`define CAL_LOCK_ADDR 16'h2230
`define OFS_HS_TIA_ADDR 16'h2234
`define GAIN_TEMP_ADDR 16'h2238
`define OFS_TEMP_ADDR 16'h223C
`define GAIN_AUX_G1_ADDR 16'h2240
`define OFS_AUX_G1_ADDR 16'h2244
`define GAIN_AUX_G1P5_ADDR 16'h2270
`define GAIN_AUX_G2_ADDR 16'h2274
`define GAIN_AUX_G4_ADDR 16'h2278
`define GAIN_HS_TIA_ADDR 16'h2284
`define OFS_LP_TIA_ADDR 16'h2288
`define GAIN_LP_TIA_ADDR 16'h228C
`define GAIN_AUX_G9_ADDR 16'h2298
`define OFS_AUX_G2_ADDR 16'h22C8
`define OFS_AUX_G1P5_ADDR 16'h22CC
`define OFS_AUX_G9_ADDR 16'h22D0
`define OFS_AUX_G4_ADDR 16'h22D4
`define BUF_CFG_ADDR 16'h238C
`define STATUS_ADDR 16'h2400
`define RPT_EN_BIT 0
`define RPT_COUNT_LSB 4
`define RPT_COUNT_MSB 11
`define RPT_CTRL_RESET 32'h0000_0160
`define RPT_COUNT_ALL_ONES 8'hFF
`define RPT_MAX_CONVERSIONS 9'h100
`define BUF_CFG_RESET 32'h005F_3D00
`define BUF_FIXED_LSB 9
`define AMP_DIS_LSB 4
`define AMP_DIS_MSB 8
`define CHOP_DIS_LSB 0
`define CHOP_DIS_MSB 3
`define CAL_UNLOCK_KEY 32'hDE87_A5AF
`define CAL_FIELD_MSB 14
`define GAIN_CAL_RESET 15'h4000
`define OFFSET_CAL_RESET 15'h0000
`define STAT_BUSY_BIT 0
`define STAT_UNLOCKED_BIT 1
`define STAT_DONE_LSB 8
`define STAT_DONE_MSB 16
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

// >>> pkg/adc_cal_regs_pkg.sv
// Types shared by the ADC repeat, buffer and calibration register block
package adc_cal_regs_pkg;
   typedef enum logic [1:0] {
      LOW_POWER_TIA, HIGH_SPEED_TIA, AUX_INPUT, TEMPERATURE_SENSOR
   } meas_channel_t;
   typedef enum logic [2:0] {
      PGA_GAIN_1, PGA_GAIN_1P5, PGA_GAIN_2, PGA_GAIN_4, PGA_GAIN_9
   } pga_gain_t;
   typedef enum logic [1:0] {
      REPEAT_IDLE, REPEAT_REQUEST, REPEAT_WAIT
   } repeat_state_t;
endpackage
